// ### src/cmt_trigger_scrub_control.v
// Purpose: Connection-management trigger, scrub and event flag registers
//          on the device control bus.
// Assumes: Control bus strobes, line-state indications and symbol tick
//          come from logic on ref_clk_in, so none is synchronised here.
// Notes:   Read data appears one cycle after the read strobe.
`include "cmt_regs.vh"

module cmt_trigger_scrub_control
#(
   parameter THR_BITS = 8
)
(
   input  wire       ref_clk_in,
   input  wire       reset_n_in,
   input  wire [7:0] cb_addr_in,
   input  wire [7:0] cb_wdata_in,
   input  wire       cb_wr_in,
   input  wire       cb_rd_in,
   input  wire       enable_scrub_on_trigger_in,
   input  wire       noise_timer_expired_in,
   input  wire       quiet_state_in,
   input  wire       halt_state_in,
   input  wire       master_state_in,
   input  wire       super_idle_state_in,
   input  wire       symbol_tick_in,
   output wire [7:0] cb_rdata_out,
   output wire       connection_service_event_out,
   output wire       conditional_write_inhibit_out,
   output wire       write_reject_flag_out,
   output wire       config_protect_out,
   output wire       transmit_state_protect_out,
   output wire       mode_load_out,
   output wire [2:0] current_transmit_mode_out,
   output wire       quiet_symbols_out,
   output wire       scrub_invalid_out,
   output wire       scrub_pairs_out
);

   ////////////////////////////////////////////////////////////////////////
   // Local definitions

   localparam ST_IDLE    = 2'b00;
   localparam ST_INVALID = 2'b01;
   localparam ST_SCRUB   = 2'b10;

   // Modes that put quiet symbols on the line
   function is_quiet_mode;
      input [2:0] mode;
      begin
         case (mode)
            `TM_OFF:    is_quiet_mode = 1'b1;
            `TM_RSVD_A: is_quiet_mode = 1'b1;
            `TM_QUIET:  is_quiet_mode = 1'b1;
            `TM_RSVD_B: is_quiet_mode = 1'b1;
            default:    is_quiet_mode = 1'b0;
         endcase
      end
   endfunction

   // Pack the two condition bits into a byte; reserved bits read zero
   function [7:0] pack_flags;
      input [1:0] f;
      begin
         pack_flags = 8'h00;
         pack_flags[`CMT_BIT_TRIG]  = f[1];
         pack_flags[`CMT_BIT_SCRUB] = f[0];
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Registers

   reg [1:0]          flags_ff;
   reg [1:0]          nxt_flags;
   reg [1:0]          compare_ff;
   reg [1:0]          nxt_compare;
   reg [1:0]          mask_ff;
   reg [THR_BITS-1:0] threshold_ff;
   reg [7:0]          trig_def_ff;
   reg [7:0]          rdata_ff;
   reg [7:0]          nxt_rdata;
   reg                cse_ff;
   reg                cwi_ff;
   reg                nxt_cwi;
   reg                wrej_ff;
   reg                load_ff;
   reg [2:0]          mode_ff;
   reg                quiet_ff;
   reg [4:0]          cond_q_ff;
   reg [1:0]          state_ff;
   reg [1:0]          nxt_state;
   reg [1:0]          inv_cnt_ff;
   reg [1:0]          nxt_inv_cnt;
   reg                inv_out_ff;
   reg                pairs_out_ff;

   wire [4:0]          cond_now;
   wire [4:0]          cond_rise;
   wire [4:0]          cond_en;
   wire                trigger;
   wire                scrub_start;
   wire                timer_running;
   wire                timer_expired;
   wire [THR_BITS-1:0] timer_upper;
   wire                wr_flags;
   wire                rd_flags;

   ////////////////////////////////////////////////////////////////////////
   // Trigger detection

   // Trigger on entry into a selected condition, not on its level, so a
   // long line state yields one trigger only
   assign cond_now  = {noise_timer_expired_in, quiet_state_in,
                       halt_state_in, master_state_in,
                       super_idle_state_in};
   assign cond_rise = cond_now & ~cond_q_ff;
   assign cond_en   = {trig_def_ff[`TDR_BIT_NOISE],
                       trig_def_ff[`TDR_BIT_QUIET],
                       trig_def_ff[`TDR_BIT_HALT],
                       trig_def_ff[`TDR_BIT_MASTER],
                       trig_def_ff[`TDR_BIT_SUPER_IDLE]};
   assign trigger   = |(cond_rise & cond_en);

   // Idle sequencer and stopped timer both required, so a trigger that
   // lands on the expiry edge cannot restart a scrub half-way
   assign scrub_start = trigger && enable_scrub_on_trigger_in &&
                        (state_ff == ST_IDLE) && !timer_running;

   assign wr_flags = cb_wr_in && (cb_addr_in == `CMT_ADDR_FLAGS);
   assign rd_flags = cb_rd_in && (cb_addr_in == `CMT_ADDR_FLAGS);

   ////////////////////////////////////////////////////////////////////////
   // Scrub timer

   scrub_timer
   #(
      .CNT_BITS (THR_BITS),
      .PRE_BITS (`SCRUB_PRESCALE_BITS)
   )
   u_scrub_timer
   (
      .ref_clk_in  (ref_clk_in),
      .reset_n_in  (reset_n_in),
      .start_in    (scrub_start),
      .load_in     (threshold_ff),
      .running_out (timer_running),
      .expired_out (timer_expired),
      .upper_out   (timer_upper)
   );

   ////////////////////////////////////////////////////////////////////////
   // Condition flags and compare copy

   always @*
   begin
      nxt_flags   = flags_ff;
      nxt_compare = compare_ff;
      nxt_cwi     = 1'b0;
      if (wr_flags)
      begin
         if (flags_ff[1] == compare_ff[1])
            nxt_flags[1] = cb_wdata_in[`CMT_BIT_TRIG];
         else
            nxt_cwi = 1'b1;
         if (flags_ff[0] == compare_ff[0])
            nxt_flags[0] = cb_wdata_in[`CMT_BIT_SCRUB];
         else
            nxt_cwi = 1'b1;
      end
      if (rd_flags)
         nxt_compare = flags_ff;
      // Hardware events win over a clear in the same cycle
      if (trigger)
         nxt_flags[1] = 1'b1;
      if (timer_expired)
         nxt_flags[0] = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////
   // Read mux

   always @*
   begin
      case (cb_addr_in)
         `CMT_ADDR_COMPARE:   nxt_rdata = pack_flags(compare_ff);
         `CMT_ADDR_FLAGS:     nxt_rdata = pack_flags(flags_ff);
         `CMT_ADDR_MASK:      nxt_rdata = pack_flags(mask_ff);
         `CMT_ADDR_THRESHOLD: nxt_rdata = threshold_ff;
         `CMT_ADDR_SNAPSHOT:  nxt_rdata = timer_upper;
         `CMT_ADDR_TRIG_DEF:  nxt_rdata = trig_def_ff;
         default:             nxt_rdata = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Scrub sequencer

   always @*
   begin
      nxt_state   = state_ff;
      nxt_inv_cnt = inv_cnt_ff;
      case (state_ff)
         ST_IDLE:
         begin
            if (scrub_start)
            begin
               nxt_state   = ST_INVALID;
               nxt_inv_cnt = 2'h0;
            end
         end
         ST_INVALID:
         begin
            if (timer_expired)
               nxt_state = ST_IDLE;
            else if (symbol_tick_in)
            begin
               nxt_inv_cnt = inv_cnt_ff + 2'h1;
               if (inv_cnt_ff == `SCRUB_INVALID_SYMS - 1)
                  nxt_state = ST_SCRUB;
            end
         end
         ST_SCRUB:
         begin
            if (timer_expired)
               nxt_state = ST_IDLE;
         end
         default:
         begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Clocked state

   always @(posedge ref_clk_in)
   begin
      if (!reset_n_in)
      begin
         flags_ff     <= `CMT_RST_FLAGS;
         compare_ff   <= `CMT_RST_FLAGS;
         mask_ff      <= `CMT_RST_MASK;
         threshold_ff <= `CMT_RST_THRESHOLD;
         trig_def_ff  <= `CMT_RST_TRIG_DEF;
         rdata_ff     <= 8'h00;
         cse_ff       <= 1'b0;
         cwi_ff       <= 1'b0;
         wrej_ff      <= 1'b0;
         load_ff      <= 1'b0;
         mode_ff      <= `TM_ACTIVE;
         quiet_ff     <= 1'b0;
         cond_q_ff    <= 5'h00;
         state_ff     <= ST_IDLE;
         inv_cnt_ff   <= 2'h0;
         inv_out_ff   <= 1'b0;
         pairs_out_ff <= 1'b0;
      end
      else
      begin
         flags_ff   <= nxt_flags;
         compare_ff <= nxt_compare;
         cwi_ff     <= nxt_cwi;
         cond_q_ff  <= cond_now;
         state_ff   <= nxt_state;
         inv_cnt_ff <= nxt_inv_cnt;
         cse_ff     <= |(nxt_flags & mask_ff);
         load_ff    <= trigger;
         wrej_ff    <= cb_wr_in && (cb_addr_in == `CMT_ADDR_SNAPSHOT);
         inv_out_ff   <= (nxt_state == ST_INVALID);
         pairs_out_ff <= (nxt_state == ST_SCRUB);
         if (cb_rd_in)
            rdata_ff <= nxt_rdata;
         if (trigger)
         begin
            mode_ff  <= trig_def_ff[`TDR_MODE_MSB:0];
            quiet_ff <= is_quiet_mode(trig_def_ff[`TDR_MODE_MSB:0]);
         end
         if (cb_wr_in)
         begin
            // Writes to 22h-23h and the snapshot are dropped
            case (cb_addr_in)
               `CMT_ADDR_MASK:
                  mask_ff <= {cb_wdata_in[`CMT_BIT_TRIG],
                              cb_wdata_in[`CMT_BIT_SCRUB]};
               `CMT_ADDR_THRESHOLD:
                  threshold_ff <= cb_wdata_in[THR_BITS-1:0];
               `CMT_ADDR_TRIG_DEF:
                  trig_def_ff <= cb_wdata_in;
               default:
                  mask_ff <= mask_ff;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   assign cb_rdata_out                  = rdata_ff;
   assign connection_service_event_out  = cse_ff;
   assign conditional_write_inhibit_out = cwi_ff;
   assign write_reject_flag_out         = wrej_ff;
   assign config_protect_out            = flags_ff[0];
   assign transmit_state_protect_out    = flags_ff[1];
   assign mode_load_out                 = load_ff;
   assign current_transmit_mode_out     = mode_ff;
   assign quiet_symbols_out             = quiet_ff;
   assign scrub_invalid_out             = inv_out_ff;
   assign scrub_pairs_out               = pairs_out_ff;

endmodule // cmt_trigger_scrub_control

// ### include/cmt_regs.vh
// Purpose: Offsets, field positions, reset values and timing counts for
//          the connection-management trigger and scrub register bank.
// Assumes: 8-bit control bus, 100 MHz device clock.
// Notes:   Definitions only.
//
// Notes on behaviour
// - Enabled trigger sets trigger_occurred and loads the trigger mode.
// - Scrub timer counts down; at zero scrub_timer_expired is set.
// - While scrub_timer_expired is set, configuration register is protected.
// - While trigger_occurred is set, current transmit state is protected.
// - Flag with its mask bit set raises connection service event.
// - Mask at 21h: bit 7 trigger mask, bit 6 scrub mask.
// - Threshold is 8 bits at 40.96 us per count, about 10 ms.
// - Scrub starts only on trigger with scrub-on-trigger enabled.
// - Threshold writes during a scrub affect only later scrubs.
// - Snapshot register reads upper eight bits of the running timer.
// - Writes to snapshot register are dropped and raise write reject.
// - Trigger definition selects trigger events and the mode entered.
// - Flag bits differing from compare copy are not written; inhibit set.
// - Reading the flags copies them into the compare register.
// - Scrub sends two invalid symbols, then scrub pairs until expiry.
`ifndef CMT_REGS_VH
`define CMT_REGS_VH

`define CMT_ADDR_COMPARE     8'h1f
`define CMT_ADDR_FLAGS       8'h20
`define CMT_ADDR_MASK        8'h21
`define CMT_ADDR_RSVD_LO     8'h22
`define CMT_ADDR_RSVD_HI     8'h23
`define CMT_ADDR_THRESHOLD   8'h24
`define CMT_ADDR_SNAPSHOT    8'h25
`define CMT_ADDR_TRIG_DEF    8'h26

`define CMT_BIT_TRIG         7
`define CMT_BIT_SCRUB        6

`define TDR_BIT_NOISE        7
`define TDR_BIT_QUIET        6
`define TDR_BIT_HALT         5
`define TDR_BIT_MASTER       4
`define TDR_BIT_SUPER_IDLE   3
`define TDR_MODE_MSB         2

`define CMT_RST_FLAGS        2'h0
`define CMT_RST_MASK         2'h0
`define CMT_RST_THRESHOLD    8'h00
`define CMT_RST_TRIG_DEF     8'h00

`define TM_ACTIVE            3'h0
`define TM_IDLE              3'h1
`define TM_OFF               3'h2
`define TM_RSVD_A            3'h3
`define TM_MASTER            3'h4
`define TM_HALT              3'h5
`define TM_QUIET             3'h6
`define TM_RSVD_B            3'h7

`define CLK_PERIOD_PS        10000
`define SCRUB_TICK_PS        40960000
`define SCRUB_TICK_CYC       ((`SCRUB_TICK_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define SCRUB_PRESCALE_BITS  12
`define SCRUB_INVALID_SYMS   2

`endif

// ### src/scrub_timer.v
// Purpose: Down-counting scrub timer with whole-tick prescale below the
//          visible count.
// Assumes: One clock; start is a one-cycle pulse.
// Notes:   The low bits act as the tick divider, so the upper bits fall
//          once per tick.
module scrub_timer
#(
   parameter CNT_BITS = 8,
   parameter PRE_BITS = 12
)
(
   input  wire                ref_clk_in,
   input  wire                reset_n_in,
   input  wire                start_in,
   input  wire [CNT_BITS-1:0] load_in,
   output wire                running_out,
   output wire                expired_out,
   output wire [CNT_BITS-1:0] upper_out
);

   localparam W = CNT_BITS + PRE_BITS;

   reg [W-1:0] count_ff;
   reg         run_ff;
   reg         exp_ff;

   assign running_out = run_ff;
   assign expired_out = exp_ff;
   assign upper_out   = count_ff[W-1:PRE_BITS];

   always @(posedge ref_clk_in)
   begin
      if (!reset_n_in)
      begin
         count_ff <= {W{1'b0}};
         run_ff   <= 1'b0;
         exp_ff   <= 1'b0;
      end
      else
      begin
         exp_ff <= 1'b0;
         if (start_in && !run_ff)
         begin
            // Threshold is sampled only here; later writes wait
            count_ff <= {load_in, {PRE_BITS{1'b0}}};
            run_ff   <= 1'b1;
         end
         else if (run_ff)
         begin
            if (count_ff == {W{1'b0}})
            begin
               run_ff <= 1'b0;
               exp_ff <= 1'b1;
            end
            else
            begin
               count_ff <= count_ff - {{(W-1){1'b0}}, 1'b1};
            end
         end
      end
   end

endmodule // scrub_timer

// ### dv/cb_host.sv
// Purpose: Station management processor model on the control bus.
// Assumes: Strobes change at the falling edge, one cycle each.
// Notes:   Read data is taken two falling edges after the strobe.
module cb_host
(
   input  logic       ref_clk_in,
   input  logic [7:0] cb_rdata_out,
   output logic [7:0] cb_addr_in,
   output logic [7:0] cb_wdata_in,
   output logic       cb_wr_in,
   output logic       cb_rd_in
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      cb_addr_in = 8'h00;
      cb_wdata_in = 8'h00;
      cb_wr_in = 1'b0;
      cb_rd_in = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      if (a == 8'h22 || a == 8'h23)
         return;
      @(negedge ref_clk_in);
      cb_addr_in = a;
      cb_wdata_in = d;
      cb_wr_in = 1'b1;
      @(negedge ref_clk_in);
      cb_wr_in = 1'b0;
      // Released lines carry junk so a stale value never looks valid
      cb_addr_in = ~a;
      cb_wdata_in = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge ref_clk_in);
      cb_addr_in = a;
      cb_rd_in = 1'b1;
      @(negedge ref_clk_in);
      cb_rd_in = 1'b0;
      cb_addr_in = ~a;
      @(negedge ref_clk_in);
      d = cb_rdata_out;
   endtask
endmodule // cb_host

// ### dv/cmt_checker_properties.sv
// Purpose: Port-level properties of the trigger and scrub bank.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Bound to every instance of the bank.
module cmt_checker
(
   input logic       ref_clk_in,
   input logic       reset_n_in,
   input logic [7:0] cb_addr_in,
   input logic       cb_wr_in,
   input logic       cb_rd_in,
   input logic [7:0] cb_rdata_out,
   input logic       conditional_write_inhibit_out,
   input logic       write_reject_flag_out,
   input logic       config_protect_out,
   input logic       transmit_state_protect_out,
   input logic       mode_load_out,
   input logic [2:0] current_transmit_mode_out,
   input logic       quiet_symbols_out,
   input logic       scrub_invalid_out,
   input logic       scrub_pairs_out
);
   default clocking dc @(posedge ref_clk_in); endclocking
   default disable iff (!reset_n_in);
   mode_pulse_a: assert property (mode_load_out |=> !mode_load_out)
      else $error("mode load longer than one cycle");
   load_flag_a: assert property (mode_load_out |-> transmit_state_protect_out)
      else $error("mode load without trigger flag");
   mode_hold_a: assert property (!mode_load_out |-> $stable(current_transmit_mode_out))
      else $error("mode changed without load");
   quiet_map_a: assert property (quiet_symbols_out == current_transmit_mode_out[1])
      else $error("quiet symbols disagree with mode");
   expiry_cause_a: assert property ($rose(config_protect_out) &&
      !$past(cb_wr_in && cb_addr_in == 8'h20) |->
      $past(scrub_invalid_out || scrub_pairs_out))
      else $error("scrub flag set without a scrub");
   reject_a: assert property (cb_wr_in && cb_addr_in == 8'h25 |=> write_reject_flag_out)
      else $error("snapshot write not rejected");
   inhibit_cause_a: assert property (conditional_write_inhibit_out |-> $past(cb_wr_in && cb_addr_in == 8'h20))
      else $error("inhibit without flag write");
   trig_sticky_a: assert property (transmit_state_protect_out && !(cb_wr_in && cb_addr_in == 8'h20) |=> transmit_state_protect_out)
      else $error("trigger flag dropped");
   scrub_sticky_a: assert property (config_protect_out && !(cb_wr_in && cb_addr_in == 8'h20) |=> config_protect_out)
      else $error("scrub flag dropped");
   rsvd_read_a: assert property (cb_rd_in && cb_addr_in[7:1] == 7'h11 |=> cb_rdata_out == 8'h00)
      else $error("reserved read not zero");
   scrub_phase_a: assert property (!(scrub_invalid_out && scrub_pairs_out))
      else $error("invalid and pair phases overlap");
endmodule // cmt_checker
bind cmt_trigger_scrub_control cmt_checker cmt_checker_inst
(
   .ref_clk_in, .reset_n_in, .cb_addr_in, .cb_wr_in, .cb_rd_in,
   .cb_rdata_out, .conditional_write_inhibit_out, .write_reject_flag_out,
   .config_protect_out, .transmit_state_protect_out, .mode_load_out,
   .current_transmit_mode_out, .quiet_symbols_out, .scrub_invalid_out,
   .scrub_pairs_out
);

// ### dv/cmt_trigger_scrub_control_tb_top.sv
// Purpose: Self-checking bench for the trigger and scrub bank.
// Assumes: Inputs change at the falling edge of a 100 MHz clock.
// Notes:   Threshold 2 keeps the scrub near 8192 cycles.
module cmt_trigger_scrub_control_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk_in, reset_n_in, enable_scrub_on_trigger_in, symbol_tick_in;
   logic noise_timer_expired_in, quiet_state_in, halt_state_in;
   logic master_state_in, super_idle_state_in, cb_wr_in, cb_rd_in;
   logic [7:0] cb_addr_in, cb_wdata_in, cb_rdata_out, v;
   logic [2:0] current_transmit_mode_out;
   logic connection_service_event_out, conditional_write_inhibit_out;
   logic write_reject_flag_out, config_protect_out, mode_load_out;
   logic transmit_state_protect_out, quiet_symbols_out;
   logic scrub_invalid_out, scrub_pairs_out;
   logic [4:0] ls;
   int err_count, comparisons, cyc, n_rej, n_cwi, n_ld, n, t0, src, m;
   int seed;
   assign {noise_timer_expired_in, quiet_state_in, halt_state_in,
           master_state_in, super_idle_state_in} = ls;
   cmt_trigger_scrub_control cmt_trigger_scrub_control_inst
   (
      .ref_clk_in, .reset_n_in, .cb_addr_in, .cb_wdata_in, .cb_wr_in,
      .cb_rd_in, .enable_scrub_on_trigger_in, .noise_timer_expired_in,
      .quiet_state_in, .halt_state_in, .master_state_in,
      .super_idle_state_in, .symbol_tick_in, .cb_rdata_out,
      .connection_service_event_out, .conditional_write_inhibit_out,
      .write_reject_flag_out, .config_protect_out,
      .transmit_state_protect_out, .mode_load_out,
      .current_transmit_mode_out, .quiet_symbols_out, .scrub_invalid_out,
      .scrub_pairs_out
   );
   cb_host cb_host_inst
   (
      .ref_clk_in, .cb_rdata_out, .cb_addr_in, .cb_wdata_in, .cb_wr_in,
      .cb_rd_in
   );
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      ref_clk_in = 1'b0;
      forever #5 ref_clk_in = ~ref_clk_in;
   end
   // Pulses last one cycle, so they are counted rather than sampled
   always @(posedge ref_clk_in)
   begin
      cyc <= cyc + 1;
      n_rej <= n_rej + int'(write_reject_flag_out);
      n_cwi <= n_cwi + int'(conditional_write_inhibit_out);
      n_ld <= n_ld + int'(mode_load_out);
      if (cyc == 40000)
      begin
         err_count++;
         report_and_stop();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         err_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      chk({7'h00, got}, {7'h00, exp});
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      cb_host_inst.wr(a, d);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      cb_host_inst.rd(a, d);
      chk(d, exp);
   endtask
   task automatic trig(input int k);
      @(negedge ref_clk_in);
      ls[4-k] = 1'b1;
      repeat (2) @(negedge ref_clk_in);
      ls[4-k] = 1'b0;
   endtask
   task automatic stick();
      @(negedge ref_clk_in);
      symbol_tick_in = 1'b1;
      @(negedge ref_clk_in);
      symbol_tick_in = 1'b0;
   endtask
   function automatic logic quiet_exp(input int md);
      return md == 2 || md == 3 || md == 6 || md == 7;
   endfunction
   task report_and_stop();
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      {err_count, comparisons, cyc, n_rej, n_cwi, n_ld} = '0;
      seed = 32'h033403fe;
      {reset_n_in, enable_scrub_on_trigger_in, symbol_tick_in, ls} = '0;
      repeat (20) @(negedge ref_clk_in);
      reset_n_in = 1'b1;
      rdc(8'h20, 8'h00);
      rdc(8'h22, 8'h00);
      rdc(8'h23, 8'h00);
      rdc(8'h26, 8'h00);
      repeat (4)
      begin
         v = 8'($random(seed));
         wr(8'h21, v);
         rdc(8'h21, v & 8'hc0);
         wr(8'h24, v);
         rdc(8'h24, v);
      end
      n = n_rej;
      wr(8'h25, 8'h5a);
      // The pulse is counted one edge after it appears
      @(negedge ref_clk_in);
      chk(8'(n_rej - n), 8'h01);
      rdc(8'h25, 8'h00);
      $display("test registers done");
      wr(8'h21, 8'h80);
      for (m = 0; m < 8; m++)
      begin
         src = (m + $unsigned($random(seed))) % 5;
         wr(8'h26, (8'h80 >> src) | 8'(m));
         trig((src + 1) % 5);
         chk_bit(transmit_state_protect_out, 1'b0);
         trig(src);
         chk(8'(n_ld), 8'(m + 1));
         chk(8'(current_transmit_mode_out), 8'(m));
         chk_bit(quiet_symbols_out, quiet_exp(m));
         chk_bit(connection_service_event_out, 1'b1);
         chk_bit(scrub_invalid_out, 1'b0);
         n = n_cwi;
         wr(8'h20, 8'h00);
         @(negedge ref_clk_in);
         chk(8'(n_cwi - n), 8'h01);
         chk_bit(transmit_state_protect_out, 1'b1);
         rdc(8'h20, 8'h80);
         wr(8'h20, 8'h00);
         rdc(8'h20, 8'h00);
         chk_bit(connection_service_event_out, 1'b0);
      end
      $display("test triggers done");
      wr(8'h24, 8'h02);
      wr(8'h26, 8'h81);
      wr(8'h21, 8'h40);
      enable_scrub_on_trigger_in = 1'b1;
      trig(0);
      t0 = cyc;
      chk_bit(scrub_invalid_out, 1'b1);
      wr(8'h24, 8'h01);
      rdc(8'h25, 8'h01);
      stick();
      stick();
      @(negedge ref_clk_in);
      chk_bit(scrub_pairs_out, 1'b1);
      chk_bit(scrub_invalid_out, 1'b0);
      while (!config_protect_out && cyc < t0 + 9000)
         @(negedge ref_clk_in);
      chk_bit(cyc - t0 >= 8186 && cyc - t0 <= 8198, 1'b1);
      chk_bit(scrub_pairs_out, 1'b0);
      chk_bit(connection_service_event_out, 1'b1);
      rdc(8'h20, 8'hc0);
      rdc(8'h1f, 8'hc0);
      wr(8'h20, 8'h80);
      rdc(8'h20, 8'h80);
      chk_bit(config_protect_out, 1'b0);
      $display("test scrub done");
      report_and_stop();
   end
endmodule // cmt_trigger_scrub_control_tb_top
